//--- dv/adsc_conv_model.sv
// Behavioural converter answering each conversion start
`timescale 1ns/1ps
module adsc_conv_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conv_start,
  input wire logic slow,
  output logic     conv_done
);
  int cnt_q;

  // Done is held high four cycles so the synchroniser sees it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 0;
    end else if (conv_start) begin
      cnt_q <= slow ? 24 : 7;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end

  assign conv_done = cnt_q != 0 && cnt_q <= 4;
endmodule

//--- dv/adsc_monitor.sv
// Port checker for the sample/convert sequencer
`timescale 1ns/1ps
module adsc_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_en,
  input wire logic        analog_power,
  input wire logic [3:0]  sh_sample,
  input wire logic        conv_start,
  input wire logic [1:0]  conv_channel
);
  logic [15:0] one_q;
  logic [15:0] two_q;
  logic [2:0]  sw_q;
  logic [1:0]  last_q;
  logic [3:0]  mask;
  logic        sim;

  // Shadow of control registers one and two and of recent writes that set the sample bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      one_q <= 16'h0000;
      two_q <= 16'h0000;
      sw_q <= 3'h0;
    end else begin
      sw_q <= {sw_q[1:0], wr_en && addr == 4'h0 && wdata[1]};
      if (wr_en && addr == 4'h0) begin
        one_q <= wdata;
      end
      if (wr_en && addr == 4'h1) begin
        two_q <= wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_q <= 2'h0;
    end else if (conv_start) begin
      last_q <= conv_channel;
    end
  end

  assign mask = one_q[10] ? 4'h1 :
                two_q[9] ? 4'hf : two_q[8] ? 4'h3 : 4'h1;
  assign sim = one_q[3] && mask != 4'h1;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  off_quiet_a:
    assert property (!analog_power && !$past(analog_power)
      |-> sh_sample == 4'h0 && !conv_start) else $error("busy while off");
  start_pulse_a:
    assert property (conv_start |=> !conv_start) else $error("long start");
  sh_mask_a:
    assert property (analog_power |-> (sh_sample & ~mask) == 4'h0)
      else $error("extra amplifier sampling");
  chan_range_a:
    assert property (conv_start && analog_power |-> mask[conv_channel])
      else $error("channel out of range");
  conv_held_a:
    assert property (conv_start |-> !sh_sample[conv_channel])
      else $error("converting while sampling");
  sim_hold_a:
    assert property (conv_start && sim |-> sh_sample == 4'h0)
      else $error("simultaneous resample early");
  conv_order_a:
    assert property (conv_start && conv_channel != 2'h0
      |-> conv_channel == last_q + 2'h1) else $error("conversion order");
  manual_start_a:
    assert property ($rose(sh_sample[0]) && !one_q[2] && mask == 4'h1
      |-> sw_q != 3'h0) else $error("manual resample without write");
  resume_hold_a:
    assert property ($fell(sh_sample[0]) && analog_power
      |-> conv_start && conv_channel == 2'h0)
      else $error("channel zero stopped sampling early");

  cover property (conv_start && conv_channel == 2'h3);
  cover property (conv_start && sim);
  cover property ($fell(analog_power) && $past(sh_sample) != 4'h0);
endmodule

bind adsc_sequencer adsc_monitor u_mon (.clk, .reset_n, .addr, .wdata,
  .wr_en, .analog_power, .sh_sample, .conv_start, .conv_channel);

//--- dv/test_adc_sample_convert_sequencer.sv
// Self-checking bench for the sample/convert sequencer
`timescale 1ns/1ps
module test_adc_sample_convert_sequencer;
  localparam int RC_CYC = 6;
  localparam int SAMPLE_TIME_COUNT = 5;
  logic        clk;
  logic        reset_n;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rdata;
  logic        rc_osc;
  logic        ext_trigger;
  logic        conv_done;
  logic        analog_power;
  logic [3:0]  sh_sample;
  logic        conv_start;
  logic [1:0]  conv_channel;
  logic        slow;
  logic [5:0]  conv_log[$];
  logic [15:0] v;
  int          bad_count;
  int          checks_done;
  int          b;
  int          n;

  adsc_sequencer dut (.clk, .reset_n, .addr, .wdata, .wr_en, .rd_en,
    .rdata, .rc_osc, .ext_trigger, .conv_done, .analog_power,
    .sh_sample, .conv_start, .conv_channel);
  adsc_conv_model u_conv (.clk, .reset_n, .conv_start, .slow, .conv_done);

  always #5 clk = ~clk;
  always #30 rc_osc = ~rc_osc;
  always @(posedge clk) begin
    if (conv_start) begin
      conv_log.push_back({sh_sample, conv_channel});
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_sh(input logic [3:0] exp);
    n = 0;
    while (sh_sample !== exp && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    cmp(16'(sh_sample), 16'(exp));
    if (n == 400) final_report();
  endtask

  task automatic wait_conv(input int k);
    n = 0;
    while (conv_log.size() < k && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    cmp(16'(conv_log.size() >= k), 16'h0001);
    if (n == 2000) final_report();
  endtask

  task automatic test_regs();
    for (int a = 0; a < 7; a++) begin
      rd(4'(a), v);
      cmp(v, adsc_pkg::RESET_VALUE);
    end
    wr(4'h2, 16'h1f02);
    wr(4'h6, 16'hffff);
    wr(4'h0, 16'h0001);
    rd(4'h2, v);
    cmp(v, 16'h1f02);
    rd(4'h6, v);
    cmp(v, 16'h0000);
    rd(4'h0, v);
    cmp(v, 16'h0000);
    $display("test regs done");
  endtask

  task automatic test_manual();
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h800a);
    wait_sh(4'h1);
    cmp(16'(analog_power), 16'h0001);
    rd(4'h0, v);
    cmp(v & 16'h0002, 16'h0002);
    b = conv_log.size();
    repeat (10) @(posedge clk);
    wr(4'h0, 16'h8008);
    wait_conv(b + 1);
    cmp(16'(conv_log[b]), 16'h0000);
    n = 0;
    v = 16'h0000;
    while (v[0] !== 1'b1 && n < 50) begin
      rd(4'h0, v);
      n++;
    end
    cmp(v & 16'h0001, 16'h0001);
    if (v[0] !== 1'b1) final_report();
    repeat (20) @(posedge clk);
    cmp(16'(sh_sample), 16'h0000);
    cmp(16'(conv_log.size() - b), 16'h0001);
    wr(4'h0, 16'h800a);
    wait_sh(4'h1);
    rd(4'h0, v);
    cmp(v & 16'h0001, 16'h0000);
    wr(4'h0, 16'h0008);
    wait_sh(4'h0);
    $display("test manual done");
  endtask

  task automatic test_sequential();
    slow <= 1'b1;
    wr(4'h1, 16'h0200);
    wr(4'h2, 16'h0000);
    b = conv_log.size();
    wr(4'h0, 16'h80e4);
    wait_conv(b + 4);
    for (int i = 0; i < 4; i++) begin
      cmp(16'(conv_log[b + i][1:0]), 16'(i));
    end
    cmp(16'(conv_log[b + 1][5:2]), 16'h000d);
    wr(4'h0, 16'h00e4);
    wait_sh(4'h0);
    slow <= 1'b0;
    $display("test sequential done");
  endtask

  task automatic test_simultaneous();
    wr(4'h1, 16'h0100);
    b = conv_log.size();
    wr(4'h0, 16'h802c);
    wait_sh(4'h3);
    rd(4'h0, v);
    cmp(v & 16'h0002, 16'h0002);
    cmp(16'(conv_log.size() - b), 16'h0000);
    @(posedge clk);
    ext_trigger <= 1'b1;
    repeat (6) @(posedge clk);
    ext_trigger <= 1'b0;
    wait_conv(b + 2);
    cmp(16'(conv_log[b]), 16'h0000);
    cmp(16'(conv_log[b + 1]), 16'h0001);
    wait_sh(4'h3);
    wr(4'h0, 16'h002c);
    wait_sh(4'h0);
    cmp(16'(analog_power), 16'h0000);
    $display("test simultaneous done");
  endtask

  task automatic test_clocked_rc();
    wr(4'h1, 16'h0300);
    wr(4'h2, 16'h85ff);
    b = conv_log.size();
    wr(4'h0, 16'h84ea);
    wait_sh(4'h1);
    wait_conv(b + 1);
    cmp(16'(conv_log[b]), 16'h0000);
    cmp(16'(n >= (SAMPLE_TIME_COUNT - 1) * RC_CYC && n <= (SAMPLE_TIME_COUNT + 1) * RC_CYC + 2),
        16'h0001);
    rd(4'h2, v);
    cmp(v, 16'h85ff);
    wr(4'h0, 16'h04ea);
    $display("test clocked done");
  endtask

  initial begin
    clk = 1'b0;
    rc_osc = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ext_trigger = 1'b0;
    slow = 1'b0;
    bad_count = 0;
    checks_done = 0;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    test_regs();
    test_manual();
    test_sequential();
    test_simultaneous();
    test_clocked_rc();
    final_report();
  end
endmodule

//--- pkg/adsc_pkg.sv
// Constants and types for the sample/convert sequencer
package adsc_pkg;
  localparam int          DATA_W       = 16;
  localparam int          ADDR_W       = 4;
  localparam int          DIV_W        = 8;
  localparam int          SAMPLE_TIME_COUNT_W       = 5;
  localparam logic [3:0]  ADDR_ONE     = 4'h0;
  localparam logic [3:0]  ADDR_TWO     = 4'h1;
  localparam logic [3:0]  ADDR_THREE   = 4'h2;
  localparam logic [3:0]  ADDR_STATUS  = 4'h3;
  localparam logic [3:0]  ADDR_SCAN_HI = 4'h4;
  localparam logic [3:0]  ADDR_SCAN_LO = 4'h5;
  // Control register one
  localparam int          ONE_ON       = 15;
  localparam int          ONE_RES12    = 10;
  localparam int          ONE_SRC_HI   = 7;
  localparam int          ONE_SRC_LO   = 5;
  localparam int          ONE_SIM      = 3;
  localparam int          ONE_AUTO     = 2;
  localparam int          ONE_SAMPLE_BIT     = 1;
  localparam int          ONE_DONE     = 0;
  // Control register two
  localparam int          TWO_CH_HI    = 9;
  localparam int          TWO_CH_LO    = 8;
  // Control register three
  localparam int          THR_RC       = 15;
  localparam int          THR_SAMPLE_TIME_COUNT_HI  = 12;
  localparam int          THR_SAMPLE_TIME_COUNT_LO  = 8;
  localparam int          THR_DIV_HI   = 7;
  localparam int          THR_DIV_LO   = 0;
  localparam logic [15:0] RESET_VALUE  = 16'h0000;
  localparam logic [2:0]  SRC_SOFT     = 3'h0;
  localparam logic [2:0]  SRC_CLOCKED  = 3'h7;
  localparam logic [1:0]  CHANNEL_COUNT_SEL_ONE     = 2'h0;
  localparam logic [1:0]  CHANNEL_COUNT_SEL_TWO     = 2'h1;
  localparam logic [1:0]  LAST_OF_TWO  = 2'h1;
  localparam logic [1:0]  LAST_OF_FOUR = 2'h3;
  typedef enum logic [1:0] {
    ADSC_IDLE,
    ADSC_SAMPLE,
    ADSC_START,
    ADSC_WAIT
  } adsc_state_t;
endpackage

//--- pkg/adsc_tick_if.sv
// Conversion clock settings and tick between sequencer and tick generator
`timescale 1ns/1ps
interface adsc_tick_if;
  logic                      enable;
  logic                      rc_sel;
  logic [adsc_pkg::DIV_W-1:0] divider;
  logic                      tick;
  modport gen (input enable, input rc_sel, input divider, output tick);
  modport seq (output enable, output rc_sel, output divider, input tick);
endinterface

//--- src/adsc_sequencer.sv
// Sample/convert sequencer with its control registers
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module adsc_sequencer (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic [adsc_pkg::ADDR_W-1:0] addr,
  input  wire logic [adsc_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [adsc_pkg::DATA_W-1:0] rdata,
  input  wire logic                        rc_osc,
  input  wire logic                        ext_trigger,
  input  wire logic                        conv_done,
  output logic                             analog_power,
  output logic      [3:0]                  sh_sample,
  output logic                             conv_start,
  output logic      [1:0]                  conv_channel
);
  logic [adsc_pkg::DATA_W-1:0] one_q;
  logic [adsc_pkg::DATA_W-1:0] two_q;
  logic [adsc_pkg::DATA_W-1:0] three_q;
  logic [adsc_pkg::DATA_W-1:0] scan_hi_q;
  logic [adsc_pkg::DATA_W-1:0] scan_lo_q;
  logic                        sample_bit_q;
  logic                        done_q;
  adsc_pkg::adsc_state_t       state_q;
  adsc_pkg::adsc_state_t       state_d;
  logic [1:0]                  ch_q;
  logic [1:0]                  ch_d;
  logic [adsc_pkg::SAMPLE_TIME_COUNT_W-1:0] smp_cnt_q;
  logic [3:0]                  sh_d;
  logic                        trig_meta_q;
  logic                        trig_sync_q;
  logic                        trig_prev_q;
  logic                        done_meta_q;
  logic                        done_sync_q;
  logic                        done_prev_q;
  logic                        ext_edge;
  logic                        done_edge;
  logic                        on;
  logic                        auto;
  logic                        simul;
  logic [2:0]                  src;
  logic [adsc_pkg::SAMPLE_TIME_COUNT_W-1:0] sample_time_count;
  logic [1:0]                  last_ch;
  logic                        wr_one;
  logic                        soft_clear;
  logic                        soft_set;
  logic                        trigger;
  logic                        seq_start;
  logic                        seq_end;
  logic                        ch_end;
  adsc_tick_if                 tif ();

  assign on     = one_q[adsc_pkg::ONE_ON];
  assign auto   = one_q[adsc_pkg::ONE_AUTO];
  assign src    = one_q[adsc_pkg::ONE_SRC_HI:adsc_pkg::ONE_SRC_LO];
  assign sample_time_count   = three_q[adsc_pkg::THR_SAMPLE_TIME_COUNT_HI:adsc_pkg::THR_SAMPLE_TIME_COUNT_LO];
  assign wr_one = wr_en && (addr == adsc_pkg::ADDR_ONE);
  assign soft_set   = wr_one && wdata[adsc_pkg::ONE_SAMPLE_BIT];
  assign soft_clear = wr_one && !wdata[adsc_pkg::ONE_SAMPLE_BIT];

  // Channel count; twelve-bit mode forces channel zero alone
  always_comb begin
    if (one_q[adsc_pkg::ONE_RES12]) begin
      last_ch = 2'h0;
    end else if (two_q[adsc_pkg::TWO_CH_HI:adsc_pkg::TWO_CH_LO]
                 == adsc_pkg::CHANNEL_COUNT_SEL_ONE) begin
      last_ch = 2'h0;
    end else if (two_q[adsc_pkg::TWO_CH_HI:adsc_pkg::TWO_CH_LO]
                 == adsc_pkg::CHANNEL_COUNT_SEL_TWO) begin
      last_ch = adsc_pkg::LAST_OF_TWO;
    end else begin
      last_ch = adsc_pkg::LAST_OF_FOUR;
    end
  end

  // Simultaneous mode is meaningless with a single amplifier
  assign simul = one_q[adsc_pkg::ONE_SIM] && (last_ch != 2'h0);

  assign tif.enable  = on;
  assign tif.rc_sel  = three_q[adsc_pkg::THR_RC];
  assign tif.divider = three_q[adsc_pkg::THR_DIV_HI:adsc_pkg::THR_DIV_LO];

  adsc_tad_gen u_tad (
    .clk     (clk),
    .reset_n (reset_n),
    .rc_osc  (rc_osc),
    .tif     (tif)
  );

  // Pin synchronisers for the event trigger and converter done
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      trig_prev_q <= 1'b0;
      done_meta_q <= 1'b0;
      done_sync_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      trig_meta_q <= ext_trigger;
      trig_sync_q <= trig_meta_q;
      trig_prev_q <= trig_sync_q;
      done_meta_q <= conv_done;
      done_sync_q <= done_meta_q;
      done_prev_q <= done_sync_q;
    end
  end

  assign ext_edge  = trig_sync_q && !trig_prev_q;
  assign done_edge = done_sync_q && !done_prev_q;

  // Trigger that ends sampling, per selected source
  always_comb begin
    if (src == adsc_pkg::SRC_SOFT) begin
      trigger = soft_clear;
    end else if (src == adsc_pkg::SRC_CLOCKED) begin
      trigger = (smp_cnt_q == sample_time_count);
    end else begin
      trigger = ext_edge;
    end
  end

  assign seq_start = (state_q == adsc_pkg::ADSC_IDLE) && on
                     && (auto || sample_bit_q || soft_set);
  assign ch_end    = (state_q == adsc_pkg::ADSC_WAIT) && done_edge;
  assign seq_end   = ch_end && (ch_q == last_ch);

  // Sequencer
  always_comb begin
    state_d = state_q;
    ch_d    = ch_q;
    unique case (state_q)
      adsc_pkg::ADSC_IDLE: begin
        ch_d = 2'h0;
        if (seq_start) begin
          state_d = adsc_pkg::ADSC_SAMPLE;
        end
      end
      adsc_pkg::ADSC_SAMPLE: begin
        if (trigger) begin
          state_d = adsc_pkg::ADSC_START;
        end
      end
      adsc_pkg::ADSC_START: begin
        state_d = adsc_pkg::ADSC_WAIT;
      end
      adsc_pkg::ADSC_WAIT: begin
        if (seq_end) begin
          ch_d = 2'h0;
          // Auto restarts sampling, manual waits for sample bit
          state_d = auto ? adsc_pkg::ADSC_SAMPLE
                         : adsc_pkg::ADSC_IDLE;
        end else if (ch_end) begin
          ch_d = ch_q + 2'h1;
          // Sequential: next channel samples; simultaneous: convert
          state_d = simul ? adsc_pkg::ADSC_START
                          : adsc_pkg::ADSC_SAMPLE;
        end
      end
    endcase
    if (!on) begin
      state_d = adsc_pkg::ADSC_IDLE;
      ch_d    = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= adsc_pkg::ADSC_IDLE;
      ch_q    <= 2'h0;
    end else begin
      state_q <= state_d;
      ch_q    <= ch_d;
    end
  end

  // Sample period counter in conversion clock periods
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      smp_cnt_q <= '0;
    end else if (state_q != adsc_pkg::ADSC_SAMPLE) begin
      smp_cnt_q <= '0;
    end else if (tif.tick && smp_cnt_q != sample_time_count) begin
      smp_cnt_q <= smp_cnt_q + 1'b1;
    end
  end

  // Amplifiers held in sample mode
  always_comb begin
    sh_d = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (on && i <= int'(last_ch)) begin
        if (state_q == adsc_pkg::ADSC_SAMPLE) begin
          if (simul) begin
            sh_d[i] = 1'b1;
          end else begin
            // Auto: converted channels keep sampling for their next turn
            sh_d[i] = (i == int'(ch_q)) || auto;
          end
        end else if (state_q != adsc_pkg::ADSC_IDLE) begin
          // Sequential auto mode: channels resume once converted
          sh_d[i] = auto && !simul && (i != int'(ch_q));
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_sample    <= 4'h0;
      conv_start   <= 1'b0;
      conv_channel <= 2'h0;
      analog_power <= 1'b0;
    end else begin
      sh_sample    <= sh_d;
      conv_start   <= (state_q == adsc_pkg::ADSC_START) && on;
      conv_channel <= ch_q;
      analog_power <= on;
    end
  end

  // Sample bit: hardware set wins over a software clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_bit_q <= 1'b0;
    end else if (!on) begin
      sample_bit_q <= soft_set;
    end else if (state_d == adsc_pkg::ADSC_SAMPLE
                 && state_q != adsc_pkg::ADSC_SAMPLE && auto) begin
      sample_bit_q <= 1'b1;
    end else if (wr_one) begin
      sample_bit_q <= wdata[adsc_pkg::ONE_SAMPLE_BIT];
    end else if (state_q == adsc_pkg::ADSC_SAMPLE && trigger) begin
      sample_bit_q <= 1'b0;
    end
  end

  // Done flag: the end of a sequence wins over the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
    end else if (seq_end && on) begin
      done_q <= 1'b1;
    end else if (state_d == adsc_pkg::ADSC_SAMPLE
                 && state_q != adsc_pkg::ADSC_SAMPLE) begin
      done_q <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      one_q     <= adsc_pkg::RESET_VALUE;
      two_q     <= adsc_pkg::RESET_VALUE;
      three_q   <= adsc_pkg::RESET_VALUE;
      scan_hi_q <= adsc_pkg::RESET_VALUE;
      scan_lo_q <= adsc_pkg::RESET_VALUE;
    end else if (wr_en) begin
      unique case (addr)
        adsc_pkg::ADDR_ONE:     one_q     <= wdata;
        adsc_pkg::ADDR_TWO:     two_q     <= wdata;
        adsc_pkg::ADDR_THREE:   three_q   <= wdata;
        adsc_pkg::ADDR_SCAN_HI: scan_hi_q <= wdata;
        adsc_pkg::ADDR_SCAN_LO: scan_lo_q <= wdata;
        default: ;
      endcase
    end
  end

  // Read port, data in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (rd_en) begin
      unique case (addr)
        adsc_pkg::ADDR_ONE: begin
          rdata <= one_q;
          rdata[adsc_pkg::ONE_SAMPLE_BIT] <= sample_bit_q;
          rdata[adsc_pkg::ONE_DONE] <= done_q;
        end
        adsc_pkg::ADDR_TWO:     rdata <= two_q;
        adsc_pkg::ADDR_THREE:   rdata <= three_q;
        adsc_pkg::ADDR_STATUS:  rdata <= {12'h000, state_q, ch_q};
        adsc_pkg::ADDR_SCAN_HI: rdata <= scan_hi_q;
        adsc_pkg::ADDR_SCAN_LO: rdata <= scan_lo_q;
        default:                rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule

//--- src/adsc_tad_gen.sv
// Conversion clock tick generator: divided clock or internal RC source
`timescale 1ns/1ps
module adsc_tad_gen (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic rc_osc,
  adsc_tick_if.gen  tif
);
  logic [adsc_pkg::DIV_W-1:0] cnt_q;
  logic                      rc_meta_q;
  logic                      rc_sync_q;
  logic                      rc_prev_q;
  logic                      div_tick;
  logic                      rc_tick;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rc_meta_q <= 1'b0;
      rc_sync_q <= 1'b0;
      rc_prev_q <= 1'b0;
    end else begin
      rc_meta_q <= rc_osc;
      rc_sync_q <= rc_meta_q;
      rc_prev_q <= rc_sync_q;
    end
  end

  // Period is divider plus one system clocks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (!tif.enable || div_tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign div_tick = (cnt_q == tif.divider);
  assign rc_tick  = rc_sync_q && !rc_prev_q;

  // Divider is ignored while the RC source is chosen
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tif.tick <= 1'b0;
    end else begin
      tif.tick <= tif.enable && (tif.rc_sel ? rc_tick : div_tick);
    end
  end
endmodule
